// >>> hw/ovl_limit_margin.sv
// Upper-limit and margin command registers with clamp, ramp and warning logic.
`timescale 1ns/10ps
module ovl_limit_margin #(
    parameter int TICK_CYC = ovl_pkg::SLEW_TICK_CYC
) (
    input  wire logic                 clk,
    input  wire logic                 sys_rst,
    input  wire ovl_pkg::ovl_req_t    req,
    output ovl_pkg::ovl_rsp_t         rsp,
    input  wire logic                 conv_en,
    input  wire ovl_pkg::ovl_margin_t margin_field,
    input  wire ovl_pkg::ovl_loop_t   loop,
    input  wire logic [15:0]          dflt_limit,
    input  wire logic [15:0]          dflt_margin_high,
    input  wire logic [15:0]          dflt_margin_low,
    input  wire logic                 restore,
    input  wire logic                 clear_status,
    output logic [15:0]               vout_target,
    output ovl_pkg::ovl_status_t      status,
    output logic [7:0]                status_cml,
    output logic                      alert_n
);

    // ------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------

    // Adds a signed offset to an unsigned base and saturates at both ends, so
    // a negative trim cannot wrap a small setpoint into a huge one.
    function automatic logic [15:0] add_trim(input logic [15:0] base, input logic [15:0] trim);
        logic signed [17:0] sum;
        sum = $signed({2'b00, base}) + $signed({{2{trim[15]}}, trim});
        if (sum < 0) begin
            add_trim = ovl_pkg::WORD_ZERO;
        end else if (sum > $signed({2'b00, ovl_pkg::WORD_ONES})) begin
            add_trim = ovl_pkg::WORD_ONES;
        end else begin
            add_trim = sum[15:0];
        end
    endfunction : add_trim

    // Smaller of two words.
    function automatic logic [15:0] min16(input logic [15:0] a, input logic [15:0] b);
        min16 = (a < b) ? a : b;
    endfunction : min16

    // ------------------------------------------------------------------
    // Storage
    // ------------------------------------------------------------------
    logic [15:0] upper_limit;
    logic [15:0] margin_high;
    logic [15:0] margin_low;

    // ------------------------------------------------------------------
    // Write decode
    // ------------------------------------------------------------------
    logic        wr_limit;
    logic        wr_mhigh;
    logic        wr_mlow;
    logic        wr_known;
    logic        mhigh_bad;
    logic        mlow_bad;
    logic        wr_refused;
    logic [15:0] new_mhigh_total;
    logic [15:0] new_mlow_total;

    assign wr_limit = req.wr && req.code == ovl_pkg::CMD_UPPER_LIMIT;
    assign wr_mhigh = req.wr && req.code == ovl_pkg::CMD_MARGIN_HIGH;
    assign wr_mlow  = req.wr && req.code == ovl_pkg::CMD_MARGIN_LOW;
    assign wr_known = wr_limit || wr_mhigh || wr_mlow;

    // Margin values are checked with trim folded in, against the same
    // ceiling the setpoint obeys.
    assign new_mhigh_total = add_trim(req.data, loop.trim);
    assign new_mlow_total  = add_trim(req.data, loop.trim);
    assign mhigh_bad  = wr_mhigh && new_mhigh_total > upper_limit;
    assign mlow_bad   = wr_mlow && new_mlow_total > upper_limit;
    assign wr_refused = mhigh_bad || mlow_bad;

    // ------------------------------------------------------------------
    // Upper limit register
    // ------------------------------------------------------------------
    // Takes effect in the cycle after the write with no phasing; the default
    // is reloaded from the storage or strap value on reset and restore.
    always_ff @(posedge clk) begin
        if (sys_rst || restore) begin
            upper_limit <= dflt_limit;
        end else if (wr_limit) begin
            upper_limit <= req.data;
        end
    end

    // ------------------------------------------------------------------
    // Margin registers
    // ------------------------------------------------------------------
    // A refused value is never stored; the old target stays in force.
    always_ff @(posedge clk) begin
        if (sys_rst || restore) begin
            margin_high <= dflt_margin_high;
        end else if (wr_mhigh && !mhigh_bad) begin
            margin_high <= req.data;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || restore) begin
            margin_low <= dflt_margin_low;
        end else if (wr_mlow && !mlow_bad) begin
            margin_low <= req.data;
        end
    end

    // ------------------------------------------------------------------
    // Read path and answer
    // ------------------------------------------------------------------
    logic        rd_known;
    logic [15:0] rd_word;

    always_comb begin
        rd_known = 1'b1;
        case (req.code)
            ovl_pkg::CMD_UPPER_LIMIT: rd_word = upper_limit;
            ovl_pkg::CMD_MARGIN_HIGH: rd_word = margin_high;
            ovl_pkg::CMD_MARGIN_LOW:  rd_word = margin_low;
            ovl_pkg::CMD_STATUS_CML:  rd_word = {8'h00, status_cml};
            default: begin
                rd_word  = ovl_pkg::WORD_ZERO;
                rd_known = 1'b0;
            end
        endcase
    end

    // One-cycle answer the cycle after the request.  Unknown codes are
    // refused too, so the front end never stretches a clock for them.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            rsp <= '0;
        end else begin
            rsp.ack   <= (req.wr && wr_known && !wr_refused) || (req.rd && rd_known);
            rsp.nack  <= (req.wr && !wr_known) || wr_refused || (req.rd && !rd_known);
            rsp.rdata <= (req.rd && rd_known) ? rd_word : ovl_pkg::WORD_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // Target selection
    // ------------------------------------------------------------------
    logic [15:0] raw_request;
    logic [15:0] dac_request;
    logic [15:0] goal;
    logic        viol_now;

    // Margin modes pick their own base; every other value of the field, and
    // leaving margin, returns to the setpoint, all with trim added.
    always_comb begin
        case (margin_field)
            ovl_pkg::OVL_MARGIN_HIGH: raw_request = add_trim(margin_high, loop.trim);
            ovl_pkg::OVL_MARGIN_LOW:  raw_request = add_trim(margin_low, loop.trim);
            default:                  raw_request = add_trim(loop.setpoint, loop.trim);
        endcase
    end

    // When the DAC range already sits below the limit, the DAC clamps first
    // and no warning is owed.
    assign dac_request = min16(raw_request, loop.dac_max);
    assign goal        = min16(dac_request, upper_limit);
    assign viol_now    = conv_en && dac_request > upper_limit;

    // ------------------------------------------------------------------
    // Change detection
    // ------------------------------------------------------------------
    // A violation is an event: it fires when the request or the limit moves
    // into a violating pair, not on every cycle that the pair stays put.
    logic [15:0] req_prev;
    logic [15:0] limit_prev;
    logic        viol_event;

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            req_prev   <= ovl_pkg::WORD_ZERO;
            limit_prev <= ovl_pkg::WORD_ZERO;
        end else begin
            req_prev   <= dac_request;
            limit_prev <= upper_limit;
        end
    end

    // A lowered limit counts the same as a raised request.
    assign viol_event = viol_now &&
                        (dac_request != req_prev || upper_limit != limit_prev);

    // ------------------------------------------------------------------
    // Slew tick divider
    // ------------------------------------------------------------------
    logic [ovl_pkg::TICK_CNT_W-1:0] tick_cnt;
    logic                           slew_tick;
    localparam logic [ovl_pkg::TICK_CNT_W-1:0] TICK_LAST = ovl_pkg::TICK_CNT_W'(TICK_CYC - 1);

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            tick_cnt  <= '0;
            slew_tick <= 1'b0;
        end else if (tick_cnt == TICK_LAST) begin
            tick_cnt  <= '0;
            slew_tick <= 1'b1;
        end else begin
            tick_cnt  <= tick_cnt + 1'b1;
            slew_tick <= 1'b0;
        end
    end

    // ------------------------------------------------------------------
    // Ramp
    // ------------------------------------------------------------------
    // The step is the transition rate expressed in codes per tick, so request
    // moves and margin entries use the same slope; a lowered limit is met at once.
    ovl_slew #(
        .W       (ovl_pkg::WORD_W)
    ) u_slew (
        .clk     (clk),
        .sys_rst (sys_rst),
        .tick    (slew_tick),
        .goal    (goal),
        .step    (loop.slew_step),
        .limit   (upper_limit),
        .level   (vout_target),
        .settled ()
    );

    // ------------------------------------------------------------------
    // Status bits
    // ------------------------------------------------------------------
    // Sticky until cleared; an event in the clearing cycle still lands.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status.none_above  <= 1'b0;
            status.word_vout   <= 1'b0;
            status.vout_maxmin <= 1'b0;
        end else if (viol_event) begin
            status.none_above  <= 1'b1;
            status.word_vout   <= 1'b1;
            status.vout_maxmin <= 1'b1;
        end else if (clear_status) begin
            status.none_above  <= 1'b0;
            status.word_vout   <= 1'b0;
            status.vout_maxmin <= 1'b0;
        end
        // The invalid data bit lives in the same register, so that the
        // status word keeps a single driving process.
        if (sys_rst) begin
            status.cml_data <= 1'b0;
        end else if (wr_refused) begin
            status.cml_data <= 1'b1;
        end else if (clear_status) begin
            status.cml_data <= 1'b0;
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            status_cml <= ovl_pkg::CML_ZERO;
        end else if (wr_refused) begin
            status_cml[ovl_pkg::CML_DATA_BIT] <= 1'b1;
        end else if (clear_status) begin
            status_cml <= ovl_pkg::CML_ZERO;
        end
    end

    // ------------------------------------------------------------------
    // Host alert
    // ------------------------------------------------------------------
    // Active-low alert held while any owned status bit stands; it follows
    // the event in the same cycle the bit is set.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            alert_n <= 1'b1;
        end else if (viol_event || wr_refused) begin
            alert_n <= 1'b0;
        end else if (clear_status) begin
            alert_n <= 1'b1;
        end
    end

endmodule : ovl_limit_margin

// >>> hw/ovl_pkg.sv
// Constants, types and command codes for the output limit and margin block.
// Notes on behaviour
// - Upper limit lives at command 24h, a full unsigned 16-bit word, read and written.
// - The commanded target never rises above the stored upper limit.
// - While enabled, a target change above the limit raises the warning unless the DAC clamps.
// - A request above the limit ramps to it at the transition rate; a lowered limit clamps the target at once.
// - A violation sets none-of-above, the word voltage bit and the voltage max/min bit.
// - A violation notifies the host through the warning alert line.
// - Writing a limit below the present target gives the same full violation response.
// - The limit updates on the fly and restores its default from storage or pin detection.
// - Margin-high lives at command 25h, an unsigned 16-bit word, read and written.
// - Margin-high mode drives the target to margin-high plus trim.
// - Entering or changing a margin state ramps at the transition rate.
// - Margin-high plus trim is checked against the setpoint bounds, the limit included.
// - An invalid margin write is unsupported data: set the data bit and notify the host.
// - Margin-low lives at command 26h, an unsigned 16-bit word, read and written.
// - Margin-low mode drives the target to margin-low plus trim.
// - Out-of-range writes are refused with a NACK and logged as invalid data in 7Eh.
package ovl_pkg;

    // ------------------------------------------------------------------
    // Command codes
    // ------------------------------------------------------------------
    localparam logic [7:0] CMD_UPPER_LIMIT = 8'h24;
    localparam logic [7:0] CMD_MARGIN_HIGH = 8'h25;
    localparam logic [7:0] CMD_MARGIN_LOW  = 8'h26;
    localparam logic [7:0] CMD_STATUS_CML  = 8'h7e;

    // ------------------------------------------------------------------
    // Widths and reset values
    // ------------------------------------------------------------------
    localparam int          WORD_W     = 16;
    localparam logic [15:0] WORD_ZERO  = 16'h0000;
    localparam logic [15:0] WORD_ONES  = 16'hffff;
    localparam logic [7:0]  CML_ZERO   = 8'h00;

    // Bit of the communication-status byte that records invalid data.
    localparam int          CML_DATA_BIT = 6;

    // ------------------------------------------------------------------
    // Margin field of the operation command
    // ------------------------------------------------------------------
    typedef enum logic [1:0] {
        OVL_MARGIN_OFF  = 2'b00,
        OVL_MARGIN_IGN  = 2'b01,
        OVL_MARGIN_LOW  = 2'b10,
        OVL_MARGIN_HIGH = 2'b11
    } ovl_margin_t;

    // ------------------------------------------------------------------
    // Slew tick timing
    // ------------------------------------------------------------------
    localparam int CLK_PERIOD_NS = 100;
    localparam int SLEW_TICK_NS  = 1000;
    localparam int SLEW_TICK_CYC = (SLEW_TICK_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int TICK_CNT_W    = 8;

    // ------------------------------------------------------------------
    // Carriers
    // ------------------------------------------------------------------
    // One decoded word transaction from the serial front end.
    typedef struct packed {
        logic        wr;
        logic        rd;
        logic [7:0]  code;
        logic [15:0] data;
    } ovl_req_t;

    // Answer to that transaction.
    typedef struct packed {
        logic        ack;
        logic        nack;
        logic [15:0] rdata;
    } ovl_rsp_t;

    // Warning and communication status bits this block owns.
    typedef struct packed {
        logic none_above;
        logic word_vout;
        logic vout_maxmin;
        logic cml_data;
    } ovl_status_t;

    // Working values that feed the target computation.
    typedef struct packed {
        logic [15:0] setpoint;
        logic [15:0] trim;
        logic [15:0] dac_max;
        logic [15:0] slew_step;
    } ovl_loop_t;

endpackage : ovl_pkg

// >>> hw/ovl_slew.sv
// Slew limiter that walks the output target toward its goal in fixed steps.
`timescale 1ns/10ps
module ovl_slew #(
    parameter int W = 16
) (
    input  wire logic         clk,
    input  wire logic         sys_rst,
    input  wire logic         tick,
    input  wire logic [W-1:0] goal,
    input  wire logic [W-1:0] step,
    input  wire logic [W-1:0] limit,
    output logic      [W-1:0] level,
    output logic              settled
);

    logic [W-1:0] diff_up;
    logic [W-1:0] diff_dn;

    assign diff_up = goal - level;
    assign diff_dn = level - goal;

    // Move one step per tick; a step of zero still lands on the goal so a
    // misprogrammed rate cannot leave the output stuck.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            level <= ovl_pkg::WORD_ZERO;
        end else if (level > limit) begin
            level <= limit;
        end else if (tick && level != goal) begin
            if (goal > level) begin
                level <= (step == ovl_pkg::WORD_ZERO || diff_up <= step) ? goal : level + step;
            end else begin
                level <= (step == ovl_pkg::WORD_ZERO || diff_dn <= step) ? goal : level - step;
            end
        end
    end

    // Settled flag for status readers.
    always_ff @(posedge clk) begin
        if (sys_rst) begin
            settled <= 1'b1;
        end else begin
            settled <= (level == goal);
        end
    end

endmodule : ovl_slew

// >>> dv/ovl_limit_margin_properties.sv
// Concurrent checks on the port behaviour of the limit and margin block.
`timescale 1ns/10ps
module ovl_limit_margin_properties #(
    parameter int TICK_CYC = 10
) (
    input wire logic                 clk,
    input wire logic                 sys_rst,
    input wire ovl_pkg::ovl_req_t    req,
    input wire ovl_pkg::ovl_rsp_t    rsp,
    input wire logic                 restore,
    input wire logic                 clear_status,
    input wire logic [15:0]          dflt_limit,
    input wire logic [15:0]          vout_target,
    input wire ovl_pkg::ovl_status_t status,
    input wire logic [7:0]           status_cml,
    input wire logic                 alert_n
);
    default clocking cb @(posedge clk); endclocking
    // ------------------------------------------------------------------
    // Shadow of the upper limit
    // ------------------------------------------------------------------
    // Mirrors limit writes so that a clamp can be judged from the ports alone.
    logic [15:0] lim;
    always_ff @(posedge clk) begin
        if (sys_rst || restore) begin
            lim <= dflt_limit;
        end else if (req.wr && req.code == ovl_pkg::CMD_UPPER_LIMIT) begin
            lim <= req.data;
        end
    end
    // ------------------------------------------------------------------
    // Bus steps
    // ------------------------------------------------------------------
    sequence s_taken;
        req.wr || req.rd;
    endsequence
    sequence s_answered;
        ##1 (rsp.ack || rsp.nack);
    endsequence
    // Register bus: every request answered on the next cycle, never unasked.
    ans_next_a: assert property (disable iff (sys_rst) s_taken |-> s_answered)
        else $error("request not answered one cycle later");
    no_spurious_a: assert property (disable iff (sys_rst)
        !(req.wr || req.rd) |=> !(rsp.ack || rsp.nack)) else $error("answer without request");
    unk_code_a: assert property (disable iff (sys_rst)
        (req.wr && !(req.code inside {8'h24, 8'h25, 8'h26})) ||
        (req.rd && !(req.code inside {8'h24, 8'h25, 8'h26, 8'h7e})) |=> rsp.nack && !rsp.ack)
        else $error("unsupported command not refused");
    lim_read_a: assert property (disable iff (sys_rst)
        req.rd && req.code == ovl_pkg::CMD_UPPER_LIMIT |=> rsp.ack && rsp.rdata == lim)
        else $error("limit read back wrong");
    // Target and warnings.
    lim_clamp_a: assert property (disable iff (sys_rst)
        vout_target > lim |=> vout_target <= lim) else $error("target left above limit");
    warn_set_a: assert property (disable iff (sys_rst)
        $rose(status.vout_maxmin) |-> status.none_above && status.word_vout && !alert_n)
        else $error("warning bits or alert incomplete");
    cml_set_a: assert property (disable iff (sys_rst)
        $rose(status.cml_data) |-> status_cml[ovl_pkg::CML_DATA_BIT] && !alert_n)
        else $error("invalid data not reported");
    warn_hold_a: assert property (disable iff (sys_rst)
        status.vout_maxmin && !clear_status && !restore |=> status.vout_maxmin && !alert_n)
        else $error("warning dropped without clear");
    // Reset itself is checked, so this one has no disable condition.
    reset_val_a: assert property (sys_rst |=> vout_target == 16'h0000 && alert_n &&
        status_cml == 8'h00 && status == '0) else $error("reset values wrong");
endmodule : ovl_limit_margin_properties

bind ovl_limit_margin ovl_limit_margin_properties #(.TICK_CYC(TICK_CYC)) i_ovl_props (
    .clk(clk), .sys_rst(sys_rst), .req(req), .rsp(rsp), .restore(restore),
    .clear_status(clear_status), .dflt_limit(dflt_limit), .vout_target(vout_target),
    .status(status), .status_cml(status_cml), .alert_n(alert_n));

// >>> dv/ovl_host_model.sv
// Behavioural host that issues whole-word command transactions to the block.
`timescale 1ns/10ps
module ovl_host_model (
    input  wire logic              clk,
    input  wire ovl_pkg::ovl_rsp_t rsp,
    output ovl_pkg::ovl_req_t      req
);
    initial req = '0;
    // One transfer, always a full word data inverted on release.
    task automatic xfer(input logic wr, input logic [7:0] code, input logic [15:0] data,
                        output logic ack, output logic nack, output logic [15:0] rdata);
        int i;
        @(posedge clk);
        #1;
        req = '{wr: wr, rd: !wr, code: code, data: data};
        @(posedge clk);
        #1;
        req.wr = 1'b0;
        req.rd = 1'b0;
        req.data = ~req.data;
        for (i = 0; i < 4 && !(rsp.ack || rsp.nack); i++) begin
            @(posedge clk);
            #1;
        end
        ack = rsp.ack;
        nack = rsp.nack;
        rdata = rsp.rdata;
    endtask : xfer
endmodule : ovl_host_model

// >>> dv/output_voltage_limit_margin_test.sv
// Self-checking bench for the output limit and margin block.
`timescale 1ns/10ps
module output_voltage_limit_margin_test;
    typedef struct packed {
        logic [7:0]  code;
        logic [15:0] data;
        logic        wr_ok;
        logic        rd_ok;
        logic [15:0] rd_exp;
    } ovl_row_t;
    logic clk, sys_rst, conv_en, restore, clear_status, alert_n, ack, nack;
    logic [15:0] vout_target, rdata;
    logic [7:0]  status_cml;
    ovl_pkg::ovl_req_t    req;
    ovl_pkg::ovl_rsp_t    rsp;
    ovl_pkg::ovl_margin_t margin_field;
    ovl_pkg::ovl_loop_t   loop;
    ovl_pkg::ovl_status_t status;
    int n_mismatch = 0;
    int checks = 0;
    // Writes then reads; refused writes must leave the old value.
    ovl_row_t rows [7] = '{'{8'h24, 16'h2000, 1, 1, 16'h2000}, '{8'h25, 16'h1800, 1, 1, 16'h1800},
        '{8'h26, 16'h0300, 1, 1, 16'h0300}, '{8'h25, 16'h2001, 0, 1, 16'h1800},
        '{8'h26, 16'hffff, 0, 1, 16'h0300}, '{8'h27, 16'h1234, 0, 0, 16'h0000},
        '{8'h7e, 16'h0055, 0, 1, 16'h0000}};

    ovl_limit_margin #(.TICK_CYC(2)) i_ovl_limit_margin (.clk(clk), .sys_rst(sys_rst),
        .req(req), .rsp(rsp), .conv_en(conv_en), .margin_field(margin_field), .loop(loop),
        .dflt_limit(16'h1000), .dflt_margin_high(16'h0800), .dflt_margin_low(16'h0400),
        .restore(restore), .clear_status(clear_status), .vout_target(vout_target),
        .status(status), .status_cml(status_cml), .alert_n(alert_n));
    ovl_host_model i_ovl_host_model (.clk(clk), .rsp(rsp), .req(req));

    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end

    task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, what, seen, exp);
        end
    endtask : check

    task automatic end_sim();
        $display("Counts: %0d checks, %0d mismatches", checks, n_mismatch);
        if (n_mismatch == 0 && checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask : end_sim

    // Waits for the target to land; with ramp set, every move must stay within one step.
    task automatic wait_target(input logic [15:0] goal, input logic ramp);
        logic [15:0] prev;
        logic [15:0] moved;
        int i;
        prev = vout_target;
        for (i = 0; i < 300 && vout_target !== goal; i++) begin
            @(posedge clk);
            #1;
            moved = (vout_target > prev) ? vout_target - prev : prev - vout_target;
            if (ramp && moved > loop.slew_step)
                check(vout_target, prev, "ramp step too large");
            prev = vout_target;
        end
        if (vout_target !== goal) begin
            check(vout_target, goal, "target never settled");
            end_sim();
        end else begin
            check(vout_target, goal, "settled target");
        end
    endtask : wait_target

    // A clear pulse; nothing is pending, so all status must drop.
    task automatic pulse_clear();
        @(posedge clk);
        #1;
        clear_status = 1'b1;
        @(posedge clk);
        #1;
        clear_status = 1'b0;
        check({status, alert_n, status_cml}, {4'h0, 1'b1, 8'h00}, "status after clear");
    endtask : pulse_clear

    initial begin
        sys_rst = 1'b1;
        conv_en = 1'b1;
        restore = 1'b0;
        clear_status = 1'b0;
        margin_field = ovl_pkg::OVL_MARGIN_OFF;
        loop = '{16'h0600, 16'h0000, 16'hf000, 16'h0100};
        repeat (16) @(posedge clk);
        #1;
        check({vout_target, alert_n, status_cml}, {16'h0000, 1'b1, 8'h00}, "reset outputs");
        sys_rst = 1'b0;
        // Defaults are live after reset, and the limit default again after a restore.
        i_ovl_host_model.xfer(0, 8'h24, 16'h0000, ack, nack, rdata);
        check(rdata, 16'h1000, "default limit");
        i_ovl_host_model.xfer(0, 8'h25, 16'h0000, ack, nack, rdata);
        check(rdata, 16'h0800, "default margin high");
        i_ovl_host_model.xfer(0, 8'h26, 16'h0000, ack, nack, rdata);
        check(rdata, 16'h0400, "default margin low");
        wait_target(16'h0600, 1);
        $display("done: reset and defaults");
        foreach (rows[i]) begin
            i_ovl_host_model.xfer(1, rows[i].code, rows[i].data, ack, nack, rdata);
            check({ack, nack}, {rows[i].wr_ok, !rows[i].wr_ok}, "write answer");
            if (rows[i].code != ovl_pkg::CMD_STATUS_CML) begin
                i_ovl_host_model.xfer(0, rows[i].code, 16'h0000, ack, nack, rdata);
                check({ack, rdata}, {rows[i].rd_ok, rows[i].rd_exp}, "read back");
            end
        end
        check({status.cml_data, status_cml[6], alert_n}, 3'b110, "invalid data");
        pulse_clear();
        $display("done: register table");
        // Margin high, low and back to setpoint, each plus trim and ramped.
        loop.trim = 16'h0010;
        margin_field = ovl_pkg::OVL_MARGIN_HIGH;
        wait_target(16'h1810, 1);
        margin_field = ovl_pkg::OVL_MARGIN_LOW;
        wait_target(16'h0310, 1);
        margin_field = ovl_pkg::OVL_MARGIN_IGN;
        wait_target(16'h0610, 1);
        check(status, 4'h0, "no warning inside limit");
        $display("done: margins");
        // Limit dropped below the running target: clamp, bits and alert.
        i_ovl_host_model.xfer(1, 8'h24, 16'h0500, ack, nack, rdata);
        check({ack, nack}, 2'b10, "lowered limit accepted");
        wait_target(16'h0500, 0);
        check({status, alert_n}, {4'he, 1'b0}, "limit write warning");
        pulse_clear();
        margin_field = ovl_pkg::OVL_MARGIN_HIGH;
        repeat (3) @(posedge clk);
        #1;
        check({status, alert_n}, {4'he, 1'b0}, "margin over limit");
        check(vout_target, 16'h0500, "target held at limit");
        pulse_clear();
        // The DAC ceiling below the limit suppresses the warning.
        loop.dac_max = 16'h0400;
        wait_target(16'h0400, 1);
        check(status, 4'h0, "dac limited, no warning");
        conv_en = 1'b0;
        loop.dac_max = 16'hf000;
        wait_target(16'h0500, 1);
        check(status, 4'h0, "disabled, no warning");
        $display("done: limit violations");
        restore = 1'b1;
        @(posedge clk);
        #1;
        restore = 1'b0;
        i_ovl_host_model.xfer(0, 8'h24, 16'h0000, ack, nack, rdata);
        check(rdata, 16'h1000, "restored limit");
        $display("done: restore");
        end_sim();
    end
endmodule : output_voltage_limit_margin_test
